// file: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a pin input into the system clock domain.
module pin_sync
  (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_rst_val,
    input  wire logic i_pin,
    output logic      o_sync
  );

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  // The first stage is read only by the second stage.
  always_comb
  begin
    meta_nxt = i_pin;
    sync_nxt = meta_r;
  end

  // Reset clears both stages; the output XOR then shows the instance tie-off value.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r ^ i_rst_val;

endmodule // pin_sync

`default_nettype wire

// file: src/spi_reg_pkg.sv
package spi_reg_pkg;

  // Frame field widths.
  localparam int CMD_BITS   = 8;
  localparam int ADDR_BITS  = 8;
  localparam int DATA_BITS  = 16;
  localparam int FRAME_BITS = CMD_BITS + ADDR_BITS + DATA_BITS;

  // Command byte values; shared with any master model.
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ  = 8'h03;

  // Register addresses.
  localparam logic [7:0] ADDR_OSC_FREQ_LOW    = 8'h00;
  localparam logic [7:0] ADDR_OSC_FREQ_HIGH   = 8'h01;
  localparam logic [7:0] ADDR_PULL_RANGE      = 8'h02;
  localparam logic [7:0] ADDR_FREQ_PROG_A     = 8'h03;
  localparam logic [7:0] ADDR_FREQ_PROG_B     = 8'h04;
  localparam logic [7:0] ADDR_POST_DIV_DRIVE  = 8'h05;
  localparam logic [7:0] ADDR_DIFF_DRIVER     = 8'h06;
  localparam int         NUM_REGS             = 7;

  // Register reset value.
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Timing.
  localparam int SYS_CLK_HZ      = 40_000_000;
  localparam int SCLK_MAX_HZ     = 5_000_000;
  localparam int GAP_US          = 125;
  localparam int GAP_CYCLES      = (GAP_US * (SYS_CLK_HZ / 1_000_000));
  localparam int SYNC_STAGES     = 2;

  // Frame phase.
  typedef enum logic [1:0] {
    PH_CMD,
    PH_ADDR,
    PH_DATA
  } phase_t;

  // Write port towards the register array.
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [15:0] data;
  } reg_wr_t;

endpackage

// file: src/spi_register_access_slave.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Serial clock up to 5 MHz; oversampled at 40 MHz, every rate below works.
// - Command, address and write data arrive on the master-out line.
// - Read data of the addressed register is driven on master-in.
// - Select is active low; traffic with select high is ignored.
// - Modes 0 and 3 supported; clock idle level does not matter.
// - Frame is 8-bit command, 8-bit address, then 16-bit data.
// - Every field is shifted most significant bit first.
// - Address increments after each data word within a burst.
// - Bytes arriving before the gap are treated as data for next register.
// - Addresses 00 to 06 are decoded to seven 16-bit registers.
// - Master-out is captured on the rising serial clock edge.
// - Half duplex; read data returns only after command and address.
module spi_register_access_slave
  (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sclk,
    input  wire logic        i_select_bar_n,
    input  wire logic        i_mosi,
    output logic             o_miso,
    output logic             o_miso_oe,
    output logic [15:0]      o_osc_frequency_control_low,
    output logic [15:0]      o_osc_frequency_control_high_oe,
    output logic [15:0]      o_pull_range_control,
    output logic [15:0]      o_frequency_program_control_a,
    output logic [15:0]      o_frequency_program_control_b,
    output logic [15:0]      o_post_divider_drive_strength,
    output logic [15:0]      o_differential_driver_control
  );

  logic sclk_s;
  logic sel_n_s;
  logic mosi_s;

  // Pin inputs pass two flops; select idles high after reset.
  pin_sync u_sync_sclk
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_rst_val (1'b0),
    .i_pin     (i_sclk),
    .o_sync    (sclk_s)
  );

  pin_sync u_sync_sel
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_rst_val (1'b1),
    .i_pin     (~i_select_bar_n),
    .o_sync    (sel_n_s)
  );

  pin_sync u_sync_mosi
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_rst_val (1'b0),
    .i_pin     (i_mosi),
    .o_sync    (mosi_s)
  );

  logic [15:0]              regs_r [spi_reg_pkg::NUM_REGS];
  logic [15:0]              regs_nxt [spi_reg_pkg::NUM_REGS];
  logic                     sclk_d_r;
  logic                     sclk_d_nxt;
  spi_reg_pkg::phase_t      phase_r;
  spi_reg_pkg::phase_t      phase_nxt;
  logic [4:0]               cnt_r;
  logic [4:0]               cnt_nxt;
  logic [15:0]              sh_r;
  logic [15:0]              sh_nxt;
  logic                     rd_r;
  logic                     rd_nxt;
  logic [7:0]               addr_r;
  logic [7:0]               addr_nxt;
  logic [15:0]              tx_r;
  logic [15:0]              tx_nxt;
  logic                     miso_r;
  logic                     miso_nxt;
  logic [12:0]              gap_r;
  logic [12:0]              gap_nxt;
  logic                     rise;
  logic                     fall;
  logic                     sel;
  spi_reg_pkg::reg_wr_t     wr;

  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;
  assign sel  = ~sel_n_s;

  // Read mux of the seven registers; unmapped addresses read zero.
  function automatic logic [15:0] reg_read(input logic [7:0] a,
                                           input logic [15:0] r [spi_reg_pkg::NUM_REGS]);
    logic [15:0] v;
    v = 16'h0000;
    if (a < 8'(spi_reg_pkg::NUM_REGS))
      v = r[a[2:0]];
    return v;
  endfunction

  // Frame decoder. The idle gap counter is the only thing that lets a new
  // command start a frame; a burst resumed early continues with data.
  always_comb
  begin
    sclk_d_nxt = sclk_s;
    phase_nxt  = phase_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    rd_nxt     = rd_r;
    addr_nxt   = addr_r;
    tx_nxt     = tx_r;
    miso_nxt   = miso_r;
    wr         = '0;
    gap_nxt    = gap_r;
    if (sel)
      gap_nxt = 13'h0000;
    else if (gap_r != 13'(spi_reg_pkg::GAP_CYCLES))
      gap_nxt = gap_r + 13'h0001;
    if (!sel)
    begin
      cnt_nxt  = 5'h00;
      miso_nxt = 1'b0;
      if (gap_r == 13'(spi_reg_pkg::GAP_CYCLES))
        phase_nxt = spi_reg_pkg::PH_CMD;
    end
    else if (rise)
    begin
      sh_nxt  = {sh_r[14:0], mosi_s};
      cnt_nxt = cnt_r + 5'h01;
      case (phase_r)
        spi_reg_pkg::PH_CMD:
        begin
          if (cnt_r == 5'(spi_reg_pkg::CMD_BITS - 1))
          begin
            rd_nxt    = ({sh_r[6:0], mosi_s} == spi_reg_pkg::CMD_READ);
            phase_nxt = spi_reg_pkg::PH_ADDR;
            cnt_nxt   = 5'h00;
          end
        end
        spi_reg_pkg::PH_ADDR:
        begin
          if (cnt_r == 5'(spi_reg_pkg::ADDR_BITS - 1))
          begin
            addr_nxt  = {sh_r[6:0], mosi_s};
            tx_nxt    = reg_read({sh_r[6:0], mosi_s}, regs_r);
            phase_nxt = spi_reg_pkg::PH_DATA;
            cnt_nxt   = 5'h00;
          end
        end
        spi_reg_pkg::PH_DATA:
        begin
          if (cnt_r == 5'(spi_reg_pkg::DATA_BITS - 1))
          begin
            wr.en    = ~rd_r;
            wr.addr  = addr_r;
            wr.data  = {sh_r[14:0], mosi_s};
            addr_nxt = addr_r + 8'h01;
            tx_nxt   = reg_read(addr_r + 8'h01, regs_r);
            cnt_nxt  = 5'h00;
          end
        end
        default:
        begin
          phase_nxt = spi_reg_pkg::PH_CMD;
        end
      endcase
    end
    else if (fall && phase_r == spi_reg_pkg::PH_DATA && rd_r)
    begin
      // Mode 0 and 3 master samples on rising edge; shift out on falling.
      miso_nxt = tx_r[15];
      tx_nxt   = {tx_r[14:0], 1'b0};
    end
  end

  // Register array write.
  always_comb
  begin
    for (int i = 0; i < spi_reg_pkg::NUM_REGS; i++)
    begin
      regs_nxt[i] = regs_r[i];
      if (wr.en && wr.addr == 8'(i))
        regs_nxt[i] = wr.data;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sclk_d_r <= 1'b0;
      phase_r  <= spi_reg_pkg::PH_CMD;
      cnt_r    <= 5'h00;
      sh_r     <= 16'h0000;
      rd_r     <= 1'b0;
      addr_r   <= 8'h00;
      tx_r     <= 16'h0000;
      miso_r   <= 1'b0;
      gap_r    <= 13'(spi_reg_pkg::GAP_CYCLES);
      for (int i = 0; i < spi_reg_pkg::NUM_REGS; i++)
        regs_r[i] <= spi_reg_pkg::REG_RESET;
    end
    else
    begin
      sclk_d_r <= sclk_d_nxt;
      phase_r  <= phase_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      rd_r     <= rd_nxt;
      addr_r   <= addr_nxt;
      tx_r     <= tx_nxt;
      miso_r   <= miso_nxt;
      gap_r    <= gap_nxt;
      regs_r   <= regs_nxt;
    end
  end

  // The line is driven only while selected and answering a read.
  assign o_miso    = miso_r;
  assign o_miso_oe = sel & rd_r & (phase_r == spi_reg_pkg::PH_DATA);

  assign o_osc_frequency_control_low     = regs_r[0];
  assign o_osc_frequency_control_high_oe = regs_r[1];
  assign o_pull_range_control            = regs_r[2];
  assign o_frequency_program_control_a   = regs_r[3];
  assign o_frequency_program_control_b   = regs_r[4];
  assign o_post_divider_drive_strength   = regs_r[5];
  assign o_differential_driver_control   = regs_r[6];

  // Assertions.
  sequence s_word_done;
    sel && rise && phase_r == spi_reg_pkg::PH_DATA && cnt_r == 5'd15;
  endsequence

  a_miso_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !sel |-> !o_miso_oe)
    else $error("master-in driven while deselected");

  a_addr_incr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_word_done |=> addr_r == $past(addr_r) + 8'h01)
    else $error("address did not increment after a word");

  a_write_store: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_word_done and (!rd_r && addr_r == 8'h02) |=> regs_r[2] == sh_r)
    else $error("write data not stored");

  a_ignore_desel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !sel |=> cnt_r == 5'h00)
    else $error("bits counted while deselected");

  a_cmd_to_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    sel && rise && phase_r == spi_reg_pkg::PH_CMD && cnt_r == 5'd7
      |=> phase_r == spi_reg_pkg::PH_ADDR)
    else $error("command byte not eight bits");

  a_half_duplex: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_miso_oe |-> phase_r == spi_reg_pkg::PH_DATA && rd_r)
    else $error("read data driven before address");

  a_shift_msb: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    sel && rise |=> sh_r[0] == $past(mosi_s) && sh_r[15:1] == $past(sh_r[14:0]))
    else $error("shift not msb first");

  a_no_early_cmd: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    phase_r == spi_reg_pkg::PH_DATA && !sel && gap_r < 13'd100 |=> phase_r != spi_reg_pkg::PH_CMD)
    else $error("frame restarted before gap");

endmodule // spi_register_access_slave

`default_nettype wire

// file: test/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural serial master; every pin moves on a falling system clock edge.
module spi_master_model
  (
    input  wire logic i_clk,
    input  wire logic i_miso,
    input  wire logic i_miso_oe,
    output logic      o_sclk,
    output logic      o_select_bar_n,
    output logic      o_mosi
  );
  // Idle bus: deselected, clock parked low.
  initial
  begin
    o_sclk         = 1'b0;
    o_select_bar_n = 1'b1;
    o_mosi         = 1'b0;
  end

  // Four falling system edges make half a serial period of 200 ns.
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // One frame; read bits are taken late in the high phase, since the
  // slave answers a few system clocks after the falling edge.
  task automatic frame(input logic cpol, input int nbits, input logic [127:0] tx,
                       output logic [127:0] rx);
    rx             = '0;
    // Park the clock at its idle level before selecting, so mode 3 sees no false rise.
    o_sclk         = cpol;
    tick(4);
    o_select_bar_n = 1'b0;
    tick(12);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_mosi = tx[i];
      tick(4);
      o_sclk = 1'b1;
      tick(3);
      rx = {rx[126:0], (i_miso_oe === 1'b1) ? i_miso : 1'bx};
      tick(1);
    end
    o_sclk = cpol;
    tick(12);
    o_select_bar_n = 1'b1;
    o_mosi         = ~o_mosi;
  endtask

  // Clock and data wander while the slave is not selected.
  task automatic stray(input int n);
    repeat (n)
    begin
      o_mosi = ~o_mosi;
      o_sclk = ~o_sclk;
      tick(4);
    end
  endtask
endmodule // spi_master_model

`default_nettype wire

// file: test/spi_register_access_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none

module spi_register_access_slave_bench;
  localparam logic [15:0] W [7] = '{16'h9a31, 16'h4c02, 16'h8f17, 16'h0be6,
                                    16'hc354, 16'h71a8, 16'h2d9e};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         sclk;
  logic         ss_n;
  logic         mosi;
  logic         miso;
  logic         miso_oe;
  logic [15:0]  regs [7];
  logic [15:0]  exp_r [7];
  logic [127:0] rx;
  int           n_errors = 0;
  int           cmp_count = 0;

  // Free-running 40 MHz system clock.
  always #12.5 clk = ~clk;

  spi_master_model m (.i_clk(clk), .i_miso(miso), .i_miso_oe(miso_oe), .o_sclk(sclk),
                      .o_select_bar_n(ss_n), .o_mosi(mosi));

  spi_register_access_slave dut (.i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk),
    .i_select_bar_n(ss_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
    .o_osc_frequency_control_low(regs[0]), .o_osc_frequency_control_high_oe(regs[1]),
    .o_pull_range_control(regs[2]), .o_frequency_program_control_a(regs[3]),
    .o_frequency_program_control_b(regs[4]), .o_post_divider_drive_strength(regs[5]),
    .o_differential_driver_control(regs[6]));

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_regs;
    for (int i = 0; i < 7; i++)
      chk_word(regs[i], exp_r[i]);
  endtask

  // Select stays high past the quiet time so the next frame is a command.
  task automatic gap;
    repeat (spi_reg_pkg::GAP_CYCLES + 40) @(negedge clk);
  endtask

  task automatic finish_test;
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic t_burst;
    logic [127:0] tx;
    tx = {spi_reg_pkg::CMD_WRITE, spi_reg_pkg::ADDR_OSC_FREQ_LOW, 112'h0};
    for (int i = 0; i < 7; i++)
    begin
      exp_r[i] = W[i];
      tx[111 - 16 * i -: 16] = W[i];
    end
    m.frame(1'b0, 128, tx, rx);
    repeat (8) @(negedge clk);
    chk_regs();
    gap();
    $display("test burst done");
  endtask

  task automatic t_unmapped;
    m.frame(1'b1, 32, {96'h0, spi_reg_pkg::CMD_WRITE, 8'h07, 16'hffff}, rx);
    repeat (8) @(negedge clk);
    chk_regs();
    gap();
    $display("test unmapped done");
  endtask

  // Second frame comes too soon, so its command and address become data.
  task automatic t_nogap;
    m.frame(1'b1, 32, {96'h0, spi_reg_pkg::CMD_WRITE, spi_reg_pkg::ADDR_OSC_FREQ_HIGH,
            16'h5e21}, rx);
    repeat (40) @(negedge clk);
    m.frame(1'b0, 32, {96'h0, spi_reg_pkg::CMD_WRITE, spi_reg_pkg::ADDR_FREQ_PROG_B,
            16'h3c69}, rx);
    repeat (8) @(negedge clk);
    exp_r[1] = 16'h5e21;
    exp_r[2] = {spi_reg_pkg::CMD_WRITE, spi_reg_pkg::ADDR_FREQ_PROG_B};
    exp_r[3] = 16'h3c69;
    chk_regs();
    $display("test no gap done");
  endtask

  task automatic t_stray;
    m.stray(16);
    repeat (8) @(negedge clk);
    chk_regs();
    chk_word({15'h0, miso_oe}, 16'h0000);
    gap();
    $display("test stray done");
  endtask

  // Reads alternate modes 0 and 3; address 7 is outside the map.
  task automatic t_reads;
    for (int a = 0; a < 8; a++)
    begin
      m.frame(a[0], 32, {96'h0, spi_reg_pkg::CMD_READ, a[7:0], 16'h0}, rx);
      chk_word(rx[15:0], (a < 7) ? exp_r[a] : 16'h0000);
      chk_word(rx[31:16], 16'hxxxx);
      repeat (8) @(negedge clk);
      chk_word({15'h0, miso_oe}, 16'h0000);
      gap();
    end
    $display("test reads done");
  endtask

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial
  begin
    foreach (exp_r[i])
      exp_r[i] = spi_reg_pkg::REG_RESET;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_regs();
    $display("test reset done");
    t_burst();
    t_unmapped();
    t_nogap();
    t_stray();
    t_reads();
    finish_test();
  end

  // Watchdog sized well above the roughly 60000 cycles the tests take.
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule // spi_register_access_slave_bench

`default_nettype wire
